// File: rtl/dqd_dispatch.sv
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dqd_params.svh"

module dqd_dispatch #(
	parameter int DEPTH = 8,
	parameter int PW = 8
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Avalon-MM slave
	input wire logic [31:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Incoming events
	input wire logic event_valid_i,
	input wire dqd_pkg::dqd_idx_t event_queue_i,
	input wire dqd_pkg::dqd_target_t event_target_i,
	input wire logic [PW-1:0] event_payload_i,
	output logic event_ready_o,
	// Transfer requests to the four controllers
	input wire logic [3:0] tc_ready_i,
	output logic [3:0] tr_valid_o,
	output logic [PW-1:0] tr_payload_o,
	output dqd_pkg::dqd_idx_t tr_queue_o
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] map_q;
	logic [7:0] next_map;
	logic legacy_q;
	logic next_legacy;
	logic reach_err_q;
	logic next_reach_err;
	logic ack_q;
	logic next_ack;
	logic [31:0] rdata_q;
	logic [31:0] next_rdata;

	logic [PW-1:0] mem [4][DEPTH];
	logic [AW-1:0] head_q [4];
	logic [AW-1:0] tail_q [4];
	logic [AW:0] cnt_q [4];
	logic [AW-1:0] next_head [4];
	logic [AW-1:0] next_tail [4];
	logic [AW:0] next_cnt [4];

	logic [3:0] nonempty;
	logic [3:0] full;
	logic [3:0] elig;
	logic [3:0] reach_ok;
	logic grant_v;
	dqd_pkg::dqd_idx_t grant_q;
	dqd_pkg::dqd_idx_t tc_of [4];
	logic ev_fire;
	logic wr_fire;
	logic [3:0] lower_mask;

	// ----------------------------------------
	// Queue status and controller lookup
	// ----------------------------------------
	// Field n of the map names the controller serving queue n
	always_comb begin
		for (int q = 0; q < 4; q++) begin
			tc_of[q] = map_q[2*q +: 2];
			nonempty[q] = (cnt_q[q] != '0);
			full[q] = (cnt_q[q] == FULL_CNT);
			elig[q] = nonempty[q] && tc_ready_i[tc_of[q]];
		end
	end

	// ----------------------------------------
	// Arbiter
	// ----------------------------------------
	// Normal: lowest eligible queue; a busy controller is skipped.
	// Legacy: only the lowest pending queue may go, so a busy
	// controller on the lowest pending queue stalls every higher queue.
	always_comb begin
		grant_v = 1'b0;
		grant_q = 2'd0;
		if (legacy_q) begin
			for (int q = 3; q >= 0; q--) begin
				if (nonempty[q]) begin
					grant_q = 2'(q);
				end
			end
			grant_v = elig[grant_q];
		end else begin
			for (int q = 3; q >= 0; q--) begin
				if (elig[q]) begin
					grant_v = 1'b1;
					grant_q = 2'(q);
				end
			end
		end
	end

	// One request a cycle, so a duplicate map cannot double-book
	always_comb begin
		tr_valid_o = 4'h0;
		if (grant_v) begin
			tr_valid_o[tc_of[grant_q]] = 1'b1;
		end
		tr_payload_o = mem[grant_q][head_q[grant_q]];
		tr_queue_o = grant_q;
	end

	assign lower_mask = (4'h1 << grant_q) - 4'h1;

	// ----------------------------------------
	// Event intake
	// ----------------------------------------
	// A full queue pushes back instead of dropping the event
	assign event_ready_o = !full[event_queue_i];
	assign ev_fire = event_valid_i && event_ready_o;

	// Target reach of the controller behind each queue
	always_comb begin
		for (int q = 0; q < 4; q++) begin
			case (tc_of[q])
				2'd0: reach_ok[q] = 1'(`DQD_REACH_TC0 >> event_target_i);
				2'd1: reach_ok[q] = 1'(`DQD_REACH_TC1 >> event_target_i);
				2'd2: reach_ok[q] = 1'(`DQD_REACH_TC2 >> event_target_i);
				default: reach_ok[q] = 1'(`DQD_REACH_TC3 >> event_target_i);
			endcase
		end
	end

	// ----------------------------------------
	// Queue pointers
	// ----------------------------------------
	always_comb begin
		for (int q = 0; q < 4; q++) begin
			next_head[q] = head_q[q];
			next_tail[q] = tail_q[q];
			next_cnt[q] = cnt_q[q];
			if (ev_fire && event_queue_i == 2'(q)) begin
				next_tail[q] = tail_q[q] + 1'b1;
				next_cnt[q] = next_cnt[q] + 1'b1;
			end
			if (grant_v && grant_q == 2'(q)) begin
				next_head[q] = head_q[q] + 1'b1;
				next_cnt[q] = next_cnt[q] - 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int q = 0; q < 4; q++) begin
				head_q[q] <= '0;
				tail_q[q] <= '0;
				cnt_q[q] <= '0;
			end
		end else begin
			head_q <= next_head;
			tail_q <= next_tail;
			cnt_q <= next_cnt;
		end
	end

	// Payload storage has no reset; empty slots reach tr_payload_o only while no request is valid
	always_ff @(posedge sys_clk_i) begin
		if (ev_fire) begin
			mem[event_queue_i][tail_q[event_queue_i]] <= event_payload_i;
		end
	end

	// ----------------------------------------
	// Register slave
	// ----------------------------------------
	// One wait cycle per access keeps read data registered
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
	assign wr_fire = avs_write_i && ack_q;
	assign avs_readdata_o = rdata_q;

	always_comb begin
		next_ack = (avs_read_i || avs_write_i) && !ack_q;
		next_rdata = rdata_q;
		if (avs_read_i && !ack_q) begin
			case (avs_address_i)
				`DQD_MAP_OFS: begin
					next_rdata = 32'h0;
					for (int q = 0; q < 4; q++) begin
						next_rdata[`DQD_FLD_W*q +: 2] = map_q[2*q +: 2];
					end
				end
				`DQD_CTRL_OFS: begin
					next_rdata = 32'h0;
					next_rdata[`DQD_CTRL_LEGACY_BIT] = legacy_q;
				end
				`DQD_STAT_OFS: begin
					next_rdata = 32'h0;
					next_rdata[3:0] = nonempty;
					next_rdata[`DQD_STAT_FULL_LSB +: 4] = full;
					next_rdata[`DQD_STAT_ERR_BIT] = reach_err_q;
				end
				default: next_rdata = 32'h0;
			endcase
		end
	end

	// Writes land on the edge where waitrequest is low
	always_comb begin
		next_map = map_q;
		next_legacy = legacy_q;
		next_reach_err = reach_err_q;
		if (wr_fire && avs_address_i == `DQD_MAP_OFS) begin
			// Software keeps the map one-to-one; not checked here
			if (avs_byteenable_i[0]) begin
				next_map[1:0] = avs_writedata_i[1:0];
				next_map[3:2] = avs_writedata_i[5:4];
			end
			if (avs_byteenable_i[1]) begin
				next_map[5:4] = avs_writedata_i[9:8];
				next_map[7:6] = avs_writedata_i[13:12];
			end
		end
		if (wr_fire && avs_address_i == `DQD_CTRL_OFS && avs_byteenable_i[0]) begin
			next_legacy = avs_writedata_i[`DQD_CTRL_LEGACY_BIT];
		end
		if (wr_fire && avs_address_i == `DQD_STAT_OFS && avs_byteenable_i[1]) begin
			if (avs_writedata_i[`DQD_STAT_ERR_BIT]) begin
				next_reach_err = 1'b0;
			end
		end
		// Set wins over a clear in the same cycle
		if (ev_fire && !reach_ok[event_queue_i]) begin
			next_reach_err = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			map_q <= `DQD_MAP_RST;
			legacy_q <= 1'b0;
			reach_err_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			map_q <= next_map;
			legacy_q <= next_legacy;
			reach_err_q <= next_reach_err;
			ack_q <= next_ack;
			rdata_q <= next_rdata;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking dqd_cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	one_request_a: assert property ($onehot0(tr_valid_o))
		else $error("more than one transfer request in a cycle");

	busy_tc_a: assert property ((tr_valid_o & ~tc_ready_i) == 4'h0)
		else $error("request sent to a busy controller");

	lowest_first_a: assert property (
		grant_v && !legacy_q |-> (elig & lower_mask) == 4'h0)
		else $error("lower numbered eligible queue was passed over");

	skip_busy_a: assert property (
		!legacy_q && elig != 4'h0 |-> tr_valid_o != 4'h0)
		else $error("eligible queue left waiting");

	legacy_block_a: assert property (
		legacy_q && nonempty != 4'h0 && !elig[grant_q] |-> tr_valid_o == 4'h0)
		else $error("legacy mode served below a blocked queue");

	map_route_a: assert property (
		grant_v |-> tr_valid_o == (4'h1 << map_q[2*grant_q +: 2]))
		else $error("request not routed by the map");

	reset_map_a: assert property (
		!$past(rst_n_i) |-> map_q == `DQD_MAP_RST)
		else $error("map not identity after reset");

	remap_zero_a: assert property (
		grant_v && grant_q == 2'd0 && map_q[1:0] == 2'd1 |-> tr_valid_o == 4'h2)
		else $error("queue zero not sent to controller one");

	queue_pop_a: assert property (
		grant_v && !(ev_fire && event_queue_i == grant_q)
		|=> cnt_q[$past(grant_q)] == $past(cnt_q[grant_q]) - 1'b1)
		else $error("queue depth did not drop after dispatch");

	map_read_a: assert property (
		avs_read_i && !avs_waitrequest_o && avs_address_i == `DQD_MAP_OFS
		|-> (avs_readdata_o & 32'hffffcccc) == 32'h0)
		else $error("unused map bits read nonzero");

	skip_c: cover property (!legacy_q && nonempty[0] && !elig[0] && tr_valid_o != 4'h0);
	legacy_stall_c: cover property (legacy_q && nonempty[0] && !elig[0] && elig[1]);
	remap_c: cover property (map_q[1:0] == 2'd1 && grant_v && grant_q == 2'd0);
	full_c: cover property (event_valid_i && !event_ready_o);

endmodule

// File: inc/dqd_params.svh
// Overview of operation
// - Four event queues hold events until dispatched
// - Reset maps queue n to controller n
// - Lowest numbered eligible queue wins
// - Never submit to a controller not ready
// - Skip queues whose controller is busy
// - Legacy mode: pending lower queue blocks higher
// - Each controller reaches a fixed target set
// - Map fields select each queue's controller
// - Queue zero remapped to one uses controller one
`ifndef DQD_PARAMS_SVH
`define DQD_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define DQD_MAP_OFS 32'h02a00280
`define DQD_CTRL_OFS 32'h02a00284
`define DQD_STAT_OFS 32'h02a00288

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define DQD_FLD_W 4
`define DQD_MAP_RST 8'he4
`define DQD_CTRL_LEGACY_BIT 0
`define DQD_STAT_FULL_LSB 4
`define DQD_STAT_ERR_BIT 8

// ----------------------------------------
// Target reach per controller
// ----------------------------------------
// Bit order: dec A, dec B, serial, cell, cfg xbar, bridge, pci,
// ddr, ext mem, core
`define DQD_REACH_TC0 10'h383
`define DQD_REACH_TC1 10'h3fc
`define DQD_REACH_TC2 10'h3e0
`define DQD_REACH_TC3 10'h3e0

`endif

// File: inc/dqd_pkg.sv
package dqd_pkg;
	// Index of a queue or of a transfer controller
	typedef logic [1:0] dqd_idx_t;
	// Target index carried by an event
	typedef logic [3:0] dqd_target_t;
endpackage

// File: sim/dqd_tc_model.sv
`timescale 1ns/1ps

// ------
// Four transfer controllers
// ------
module dqd_tc_model #(
	parameter int LAT = 2
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] hold_i,
	input wire logic [3:0] tr_valid_i,
	output logic [3:0] tc_ready_o,
	output logic [7:0] err_cnt_o
);
	logic [1:0] cnt [4];

	// Ready only when idle and not stalled by the bench
	always_comb begin
		for (int n = 0; n < 4; n++) begin
			tc_ready_o[n] = !hold_i[n] && cnt[n] == 2'h0;
		end
	end

	// Each accepted request keeps a controller busy for a while
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= '{default: 2'h0};
			err_cnt_o <= 8'h00;
		end else begin
			for (int n = 0; n < 4; n++) begin
				if (tr_valid_i[n] && !tc_ready_o[n]) begin
					err_cnt_o <= err_cnt_o + 8'h01;
				end
				if (tr_valid_i[n]) begin
					cnt[n] <= 2'(LAT);
				end else if (cnt[n] != 2'h0) begin
					cnt[n] <= cnt[n] - 2'h1;
				end
			end
		end
	end
endmodule

// File: sim/dqd_dispatch_tb.sv
`timescale 1ns/1ps
`include "dqd_params.svh"

module dqd_dispatch_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rd;
	logic [31:0] ard;
	logic rq = 1'b0;
	logic wq = 1'b0;
	logic ev = 1'b0;
	logic wt;
	logic erdy;
	logic [1:0] eq = 2'h0;
	logic [3:0] tgt = 4'h7;
	logic [1:0] trq;
	logic [3:0] hold = 4'hf;
	logic [3:0] rdy;
	logic [3:0] trv;
	logic [7:0] pay = 8'h00;
	logic [7:0] trp;
	logic [7:0] perr;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;

	// ------
	// Clock, design and far side
	// ------
	always #50 clk = ~clk;

	dqd_dispatch DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
		.avs_read_i(rq), .avs_write_i(wq), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hf), .avs_readdata_o(ard), .avs_waitrequest_o(wt),
		.event_valid_i(ev), .event_queue_i(eq), .event_target_i(tgt),
		.event_payload_i(pay), .event_ready_o(erdy), .tc_ready_i(rdy),
		.tr_valid_o(trv), .tr_payload_o(trp), .tr_queue_o(trq));

	dqd_tc_model PM (.sys_clk_i(clk), .rst_n_i(rst_n), .hold_i(hold),
		.tr_valid_i(trv), .tc_ready_o(rdy), .err_cnt_o(perr));

	// ------
	// Shared tasks
	// ------
	task wrap_up;
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Avalon access: hold until waitrequest low, then release
	// No local limit; the hang guard ends a stuck access
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		wq <= w;
		rq <= !w;
		do @(posedge clk); while (wt !== 1'b0);
		rd = ard;
		rq <= 1'b0;
		wq <= 1'b0;
		@(posedge clk);
	endtask

	task push(input logic [1:0] q, input logic [7:0] p);
		ev <= 1'b1;
		eq <= q;
		pay <= p;
		do @(posedge clk); while (erdy !== 1'b1);
		ev <= 1'b0;
		@(posedge clk);
	endtask

	// Waits for the next request, bounded so a stuck dispatcher shows
	task grant(input logic [3:0] v, input logic [1:0] q, input logic [7:0] p);
		int n;
		n = 0;
		do begin @(posedge clk); n++; end while (trv === 4'h0 && n < 20);
		chk(32'(trv), 32'(v));
		chk(32'(trq), 32'(q));
		chk(32'(trp), 32'(p));
	endtask

	// ------
	// Scenarios
	// ------
	task t_reset;
		bus(1'b0, `DQD_MAP_OFS, 32'h0);
		chk(rd, 32'h00003210);
		bus(1'b1, 32'h02a0028c, 32'hffffffff);
		bus(1'b0, 32'h02a0028c, 32'h0);
		chk(rd, 32'h0);
	endtask

	task t_prio;
		for (int i = 0; i < 4; i++) push(2'(3 - i), 8'(8'h10 + i));
		hold <= 4'h0;
		for (int i = 0; i < 4; i++) grant(4'(1 << i), 2'(i), 8'(8'h13 - i));
	endtask

	task t_skip;
		hold <= 4'hf;
		push(2'h0, 8'h20);
		push(2'h1, 8'h21);
		hold <= 4'h1;
		grant(4'h2, 2'h1, 8'h21);
		hold <= 4'h0;
		grant(4'h1, 2'h0, 8'h20);
	endtask

	// Blocking mode: a stalled queue zero holds back queue one
	task t_legacy;
		hold <= 4'hf;
		bus(1'b1, `DQD_CTRL_OFS, 32'h1);
		push(2'h0, 8'h30);
		push(2'h1, 8'h31);
		hold <= 4'h1;
		repeat (6) begin @(posedge clk); chk(32'(trv), 32'h0); end
		hold <= 4'h0;
		grant(4'h1, 2'h0, 8'h30);
		grant(4'h2, 2'h1, 8'h31);
		bus(1'b1, `DQD_CTRL_OFS, 32'h0);
	endtask

	task t_remap;
		hold <= 4'hf;
		bus(1'b1, `DQD_MAP_OFS, 32'h00003201);
		bus(1'b0, `DQD_MAP_OFS, 32'h0);
		chk(rd, 32'h00003201);
		push(2'h0, 8'h40);
		hold <= 4'h0;
		grant(4'h2, 2'h0, 8'h40);
		bus(1'b1, `DQD_MAP_OFS, 32'h00003210);
	endtask

	task t_full;
		hold <= 4'hf;
		for (int i = 0; i < 8; i++) push(2'h2, 8'(i));
		ev <= 1'b1;
		eq <= 2'h2;
		@(posedge clk);
		chk(32'(erdy), 32'h0);
		ev <= 1'b0;
		hold <= 4'h0;
		for (int i = 0; i < 8; i++) grant(4'h4, 2'h2, 8'(i));
	endtask

	// Reach errors are flagged but never stall dispatch
	task t_reach;
		hold <= 4'hf;
		tgt <= 4'h2;
		push(2'h1, 8'h51);
		bus(1'b0, `DQD_STAT_OFS, 32'h0);
		chk(rd, 32'h00000002);
		push(2'h0, 8'h50);
		bus(1'b0, `DQD_STAT_OFS, 32'h0);
		chk(rd, 32'h00000103);
		bus(1'b1, `DQD_STAT_OFS, 32'h00000100);
		bus(1'b0, `DQD_STAT_OFS, 32'h0);
		chk(rd, 32'h00000003);
		tgt <= 4'h7;
		hold <= 4'h0;
		grant(4'h1, 2'h0, 8'h50);
		grant(4'h2, 2'h1, 8'h51);
	endtask

	// ------
	// Main sequence and hang guard
	// ------
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset;
		t_prio;
		t_skip;
		t_legacy;
		t_remap;
		t_full;
		t_reach;
		chk(32'(perr), 32'h0);
		wrap_up;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			wrap_up;
		end
	end
endmodule
